/* File: mmgf_regs.svh */
// register offsets, field positions, reset values and timing counts of the multicast filter
`ifndef MMGF_REGS_SVH
`define MMGF_REGS_SVH

// register byte offsets
`define MMGF_OFF_CTRL       8'h00
`define MMGF_OFF_DOWN_BLOCK 8'h04
`define MMGF_OFF_CFG_TIMERS 8'h08
`define MMGF_OFF_STATUS     8'h0c
`define MMGF_OFF_MEMBER     8'h10

// control register fields
`define MMGF_CTRL_HOST_MODE 0
`define MMGF_CTRL_OVERRIDE  1
`define MMGF_CTRL_UP_BLOCK  2
`define MMGF_CTRL_RESET     3'h0

// timer field positions in the timer and status registers
`define MMGF_QI_LSB 0
`define MMGF_QI_MSB 15
`define MMGF_RI_LSB 16
`define MMGF_RI_MSB 23

// reset values
`define MMGF_DOWN_BLOCK_RESET 8'h00
`define MMGF_QI_DEFAULT       16'h007d
`define MMGF_RI_DEFAULT       8'h0a
`define MMGF_JOIN_RI          8'h0a
`define MMGF_LFSR_SEED        16'hace1

// time base
`define MMGF_SECOND_NS   1000000000
`define MMGF_CLK_NS      100
`define MMGF_TICK_CYCLES (`MMGF_SECOND_NS / `MMGF_CLK_NS)

`endif

/* File: mmgf_pkg.sv */
// types shared by the multicast group filter
package mmgf_pkg;

  // classified frame kinds, one-hot
  typedef enum logic [4:0] {
    MMGF_KIND_DATA   = 5'h01,
    MMGF_KIND_QGEN   = 5'h02,
    MMGF_KIND_QGRP   = 5'h04,
    MMGF_KIND_REPORT = 5'h08,
    MMGF_KIND_LEAVE  = 5'h10
  } mmgf_kind_t;

  typedef logic [2:0] mmgf_group_t;

endpackage : mmgf_pkg

/* File: mmgf_top.sv */
// multicast membership tracking and forwarding filter of the subscriber modem
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "mmgf_regs.svh"

module mmgf_top #(
  parameter int TICK_CYCLES = `MMGF_TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  // classified frame descriptor
  input  wire logic                 frm_valid_in,
  input  wire logic                 frm_from_rf_in,
  input  wire mmgf_pkg::mmgf_kind_t frm_kind_in,
  input  wire mmgf_pkg::mmgf_group_t frm_group_in,
  input  wire logic [7:0]           frm_resp_sec_in,
  // register port
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [31:0]          reg_rdata_out,
  // forwarding decision
  output logic                      fwd_valid_out,
  output logic                      fwd_pass_out,
  // upstream report and subscriber query requests
  output logic                      report_tx_out,
  output mmgf_pkg::mmgf_group_t     report_group_out,
  output logic                      query_tx_out
);
  import mmgf_pkg::*;

  localparam int NGRP = 8;

  // software registers
  logic [2:0]  ctrl;
  logic [7:0]  down_block;
  logic [15:0] cfg_qi;
  logic [7:0]  cfg_ri;
  // time base and query tracking
  logic [23:0] tick_cnt;
  logic        tick;
  logic [15:0] sec_since_q;
  logic [1:0]  q_seen;
  logic [15:0] qi_derived;
  logic [7:0]  ri_rx;
  logic [15:0] q_timer;
  logic [15:0] lfsr;
  // group table
  logic [NGRP-1:0] member_active;
  logic [NGRP-1:0] suppress;
  logic [NGRP-1:0] pending;
  logic [NGRP-1:0] due;
  logic [17:0]     mtimer [NGRP];
  logic [7:0]      delay  [NGRP];
  // derived values
  logic [15:0] qi_eff;
  logic [7:0]  ri_eff;
  logic [17:0] member_int;
  logic        host_mode;
  logic        is_query;
  logic        rf_frame;
  logic        sub_frame;
  logic        emit;
  mmgf_group_t emit_idx;
  logic        resp_window;
  logic [15:0] gap_sec;

  // random delay in 1..bound seconds
  function automatic logic [7:0] mmgf_rand(input logic [15:0] s, input logic [7:0] bound);
    logic [7:0] b;
    b = (bound == 8'h00) ? 8'h01 : bound;
    return 8'(s[7:0] % b) + 8'h01;
  endfunction : mmgf_rand

  // lowest set bit of a group mask
  function automatic mmgf_group_t mmgf_first(input logic [NGRP-1:0] m);
    mmgf_group_t r;
    r = 3'h0;
    for (int k = NGRP - 1; k >= 0; k--) begin
      if (m[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction : mmgf_first

  // effective timers: override or learned values
  assign host_mode   = ctrl[`MMGF_CTRL_HOST_MODE];
  assign qi_eff      = ctrl[`MMGF_CTRL_OVERRIDE] ? cfg_qi : qi_derived;
  assign ri_eff      = ctrl[`MMGF_CTRL_OVERRIDE] ? cfg_ri : ri_rx;
  assign member_int  = {1'b0, qi_eff, 1'b0} + {10'h000, ri_eff};
  assign is_query    = (frm_kind_in == MMGF_KIND_QGEN) || (frm_kind_in == MMGF_KIND_QGRP);
  assign rf_frame    = ce_in && frm_valid_in && frm_from_rf_in;
  assign sub_frame   = ce_in && frm_valid_in && !frm_from_rf_in;
  assign emit        = ce_in && (due != '0);
  assign emit_idx    = mmgf_first(due);
  assign resp_window = (sec_since_q < {8'h00, ri_eff});
  // a tick on the query edge itself still belongs to the gap being measured
  assign gap_sec     = (tick && sec_since_q != 16'hffff) ? sec_since_q + 16'h1 : sec_since_q;

  // register writes
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl       <= `MMGF_CTRL_RESET;
      down_block <= `MMGF_DOWN_BLOCK_RESET;
      cfg_qi     <= `MMGF_QI_DEFAULT;
      cfg_ri     <= `MMGF_RI_DEFAULT;
    end else if (ce_in && reg_wr_in) begin
      if (reg_addr_in == `MMGF_OFF_CTRL) begin
        ctrl <= reg_wdata_in[2:0];
      end else if (reg_addr_in == `MMGF_OFF_DOWN_BLOCK) begin
        down_block <= reg_wdata_in[7:0];
      end else if (reg_addr_in == `MMGF_OFF_CFG_TIMERS) begin
        cfg_qi <= reg_wdata_in[`MMGF_QI_MSB:`MMGF_QI_LSB];
        cfg_ri <= reg_wdata_in[`MMGF_RI_MSB:`MMGF_RI_LSB];
      end
    end
  end

  // register reads, unmapped reads return zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0;
    end else if (ce_in) begin
      if (!reg_rd_in) begin
        reg_rdata_out <= 32'h0;
      end else if (reg_addr_in == `MMGF_OFF_CTRL) begin
        reg_rdata_out <= {29'h0, ctrl};
      end else if (reg_addr_in == `MMGF_OFF_DOWN_BLOCK) begin
        reg_rdata_out <= {24'h0, down_block};
      end else if (reg_addr_in == `MMGF_OFF_CFG_TIMERS) begin
        reg_rdata_out <= {8'h0, cfg_ri, cfg_qi};
      end else if (reg_addr_in == `MMGF_OFF_STATUS) begin
        reg_rdata_out <= {8'h0, ri_eff, qi_eff};
      end else if (reg_addr_in == `MMGF_OFF_MEMBER) begin
        reg_rdata_out <= {16'h0, suppress, member_active};
      end else begin
        reg_rdata_out <= 32'h0;
      end
    end
  end

  // one second tick from the system clock
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tick_cnt <= 24'h0;
      tick     <= 1'b0;
    end else if (ce_in) begin
      tick <= (tick_cnt == 24'(TICK_CYCLES - 1));
      if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
        tick_cnt <= 24'h0;
      end else begin
        tick_cnt <= tick_cnt + 24'h1;
      end
    end
  end

  // free running random source
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      lfsr <= `MMGF_LFSR_SEED;
    end else if (ce_in) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // query interval and response interval learning from rf queries
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sec_since_q <= 16'h0;
      q_seen      <= 2'h0;
      qi_derived  <= `MMGF_QI_DEFAULT;
      ri_rx       <= `MMGF_RI_DEFAULT;
    end else if (ce_in) begin
      if (rf_frame && is_query) begin
        sec_since_q <= 16'h0;
        if (q_seen != 2'h0) begin
          q_seen     <= 2'h2;
          qi_derived <= (gap_sec > `MMGF_QI_DEFAULT) ? gap_sec : `MMGF_QI_DEFAULT;
        end else begin
          q_seen     <= 2'h1;
          qi_derived <= `MMGF_QI_DEFAULT;
        end
        ri_rx <= (frm_resp_sec_in == 8'h00) ? `MMGF_RI_DEFAULT : frm_resp_sec_in;
      end else if (tick && sec_since_q != 16'hffff) begin
        sec_since_q <= sec_since_q + 16'h1;
      end
    end
  end

  // querier toward the subscriber port while in host role
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q_timer      <= 16'h0;
      query_tx_out <= 1'b0;
    end else if (ce_in) begin
      query_tx_out <= 1'b0;
      if (!host_mode) begin
        q_timer <= 16'h0;
      end else if (tick) begin
        if (q_timer + 16'h1 >= qi_eff) begin
          q_timer      <= 16'h0;
          query_tx_out <= 1'b1;
        end else begin
          q_timer <= q_timer + 16'h1;
        end
      end
    end
  end

  // per group membership table
  generate
    for (genvar g = 0; g < NGRP; g++) begin : g_tbl
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          member_active[g] <= 1'b0;
          suppress[g]      <= 1'b0;
          pending[g]       <= 1'b0;
          due[g]           <= 1'b0;
          mtimer[g]        <= 18'h0;
          delay[g]         <= 8'h0;
        end else if (ce_in) begin
          if (emit && emit_idx == 3'(g)) begin
            due[g] <= 1'b0;
          end
          // ageing and random delay on the second tick
          if (tick && member_active[g]) begin
            if (mtimer[g] >= member_int) begin
              member_active[g] <= 1'b0;
            end else begin
              mtimer[g] <= mtimer[g] + 18'h1;
            end
          end
          if (tick && pending[g]) begin
            if (delay[g] <= 8'h1) begin
              pending[g] <= 1'b0;
              due[g]     <= 1'b1;
            end else begin
              delay[g] <= delay[g] - 8'h1;
            end
          end
          // frame events win over timer effects
          if (sub_frame && frm_group_in == 3'(g)) begin
            if (frm_kind_in == MMGF_KIND_REPORT) begin
              member_active[g] <= 1'b1;
              mtimer[g]        <= 18'h0;
              if (!suppress[g] && !pending[g] && !due[g]) begin
                pending[g] <= 1'b1;
                delay[g]   <= mmgf_rand(lfsr, `MMGF_JOIN_RI);
              end
            end else if (frm_kind_in == MMGF_KIND_LEAVE) begin
              member_active[g] <= 1'b0;
              suppress[g]      <= 1'b0;
              pending[g]       <= 1'b0;
              due[g]           <= 1'b0;
            end
          end
          if (rf_frame && frm_kind_in == MMGF_KIND_REPORT && frm_group_in == 3'(g)) begin
            if (pending[g] || due[g] || (member_active[g] && resp_window)) begin
              suppress[g] <= 1'b1;
              pending[g]  <= 1'b0;
              due[g]      <= 1'b0;
            end
          end
          if (rf_frame && (frm_kind_in == MMGF_KIND_QGEN ||
              (frm_kind_in == MMGF_KIND_QGRP && frm_group_in == 3'(g)))) begin
            suppress[g] <= 1'b0;
            if (host_mode && member_active[g] && !pending[g] && !due[g]) begin
              pending[g] <= 1'b1;
              delay[g]   <= mmgf_rand(lfsr,
                (frm_resp_sec_in == 8'h00) ? `MMGF_RI_DEFAULT : frm_resp_sec_in);
            end
          end
        end
      end
    end
  endgenerate

  // upstream report issue, one group per cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      report_tx_out    <= 1'b0;
      report_group_out <= 3'h0;
    end else if (ce_in) begin
      report_tx_out <= emit;
      if (emit) begin
        report_group_out <= emit_idx;
      end
    end
  end

  // forwarding decision for each classified frame
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fwd_valid_out <= 1'b0;
      fwd_pass_out  <= 1'b0;
    end else if (ce_in) begin
      fwd_valid_out <= frm_valid_in;
      fwd_pass_out  <= 1'b0;
      if (frm_valid_in && !frm_from_rf_in) begin
        if (frm_kind_in == MMGF_KIND_DATA) begin
          fwd_pass_out <= !ctrl[`MMGF_CTRL_UP_BLOCK];
        end else if (frm_kind_in == MMGF_KIND_LEAVE) begin
          fwd_pass_out <= 1'b1;
        end else begin
          fwd_pass_out <= 1'b0;
        end
      end else if (frm_valid_in) begin
        if (frm_kind_in == MMGF_KIND_DATA && frm_group_in == 3'h0) begin
          fwd_pass_out <= !down_block[0];
        end else if (frm_kind_in == MMGF_KIND_DATA) begin
          fwd_pass_out <= member_active[frm_group_in] && !down_block[frm_group_in];
        end else if (is_query) begin
          fwd_pass_out <= !host_mode && !down_block[frm_group_in];
        end else begin
          fwd_pass_out <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_sub_query_drop;
    sub_frame && is_query |=> fwd_valid_out && !fwd_pass_out;
  endproperty
  a_sub_query_drop: assert property (p_sub_query_drop) else $error("subscriber query passed");

  property p_rf_report_drop;
    rf_frame && (frm_kind_in == MMGF_KIND_REPORT || frm_kind_in == MMGF_KIND_LEAVE)
      |=> !fwd_pass_out;
  endproperty
  a_rf_report_drop: assert property (p_rf_report_drop) else $error("rf report passed");

  property p_rf_nonmember;
    rf_frame && frm_kind_in == MMGF_KIND_DATA && frm_group_in != 3'h0 &&
      !member_active[frm_group_in] |=> !fwd_pass_out;
  endproperty
  a_rf_nonmember: assert property (p_rf_nonmember) else $error("non member passed");

  property p_sub_data;
    sub_frame && frm_kind_in == MMGF_KIND_DATA
      |=> fwd_pass_out == !$past(ctrl[`MMGF_CTRL_UP_BLOCK]);
  endproperty
  a_sub_data: assert property (p_sub_data) else $error("subscriber data wrong");

  property p_all_hosts;
    rf_frame && frm_kind_in == MMGF_KIND_DATA && frm_group_in == 3'h0
      |=> fwd_pass_out == !$past(down_block[0]);
  endproperty
  a_all_hosts: assert property (p_all_hosts) else $error("all hosts wrong");

  property p_join;
    sub_frame && frm_kind_in == MMGF_KIND_REPORT |=> member_active[$past(frm_group_in)];
  endproperty
  a_join: assert property (p_join) else $error("report did not activate");

  property p_qi_floor;
    qi_derived >= `MMGF_QI_DEFAULT;
  endproperty
  a_qi_floor: assert property (p_qi_floor) else $error("query interval below 125");

  property p_ri_default;
    rf_frame && is_query && frm_resp_sec_in == 8'h00 |=> ri_rx == `MMGF_RI_DEFAULT;
  endproperty
  a_ri_default: assert property (p_ri_default) else $error("response default wrong");

  property p_cancel;
    rf_frame && frm_kind_in == MMGF_KIND_REPORT && pending[frm_group_in]
      |=> !pending[$past(frm_group_in)] && suppress[$past(frm_group_in)];
  endproperty
  a_cancel: assert property (p_cancel) else $error("pending join not cancelled");

  property p_leave;
    sub_frame && frm_kind_in == MMGF_KIND_LEAVE
      |=> !suppress[$past(frm_group_in)] && !member_active[$past(frm_group_in)];
  endproperty
  a_leave: assert property (p_leave) else $error("leave not applied");

  c_report_tx: cover property (report_tx_out);
  c_query_tx:  cover property (query_tx_out);
  c_rf_pass:   cover property (rf_frame && frm_kind_in == MMGF_KIND_DATA ##1 fwd_pass_out);

endmodule : mmgf_top

/* File: mmgf_far_model.sv */
// far side model: frame source for both sides, sink of report and query requests
`timescale 1ns/1ps
module mmgf_far_model (
  // clock
  input  wire logic                  ref_clk_in,
  // frame descriptor toward the filter
  output logic                       frm_valid_out,
  output logic                       frm_from_rf_out,
  output mmgf_pkg::mmgf_kind_t       frm_kind_out,
  output mmgf_pkg::mmgf_group_t      frm_group_out,
  output logic [7:0]                 frm_resp_sec_out,
  // decision and requests from the filter
  input  wire logic                  fwd_valid_in,
  input  wire logic                  fwd_pass_in,
  input  wire logic                  report_tx_in,
  input  wire mmgf_pkg::mmgf_group_t report_group_in,
  input  wire logic                  query_tx_in
);
  import mmgf_pkg::*;
  logic [7:0] rpt_seen; // groups that got an upstream report
  int         qry_cnt;  // subscriber query requests seen
  // idle values at time zero
  initial begin
    frm_valid_out = 1'b0;
    frm_from_rf_out = 1'b0;
    frm_kind_out = MMGF_KIND_DATA;
    frm_group_out = 3'h0;
    frm_resp_sec_out = 8'h00;
    rpt_seen = 8'h00;
    qry_cnt = 0;
  end
  // collect requests toward headend and subscribers
  always @(posedge ref_clk_in) begin
    if (report_tx_in) rpt_seen[report_group_in] <= 1'b1;
    if (query_tx_in) qry_cnt <= qry_cnt + 1;
  end
  // forget collected requests
  task automatic clear();
    rpt_seen = 8'h00;
    qry_cnt = 0;
  endtask : clear
  // one frame, held one cycle, fields inverted after release; returns {valid, pass}
  task automatic send(input logic rf, input mmgf_kind_t k, input mmgf_group_t g,
                      input logic [7:0] s, output logic [1:0] res);
    @(posedge ref_clk_in);
    frm_valid_out <= 1'b1;
    frm_from_rf_out <= rf;
    frm_kind_out <= k;
    frm_group_out <= g;
    frm_resp_sec_out <= s;
    @(posedge ref_clk_in);
    frm_valid_out <= 1'b0;
    frm_from_rf_out <= ~rf;
    frm_kind_out <= mmgf_kind_t'(~k);
    frm_group_out <= ~g;
    frm_resp_sec_out <= ~s;
    #1;
    res = {fwd_valid_in, fwd_pass_in};
  endtask : send
endmodule : mmgf_far_model

/* File: mmgf_top_bench.sv */
// self-checking bench of the multicast group filter
`timescale 1ns/1ps
module mmgf_top_bench;
  import mmgf_pkg::*;
  localparam int TICK = 20; // cycles per second in simulation
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        frm_valid;
  logic        frm_from_rf;
  mmgf_kind_t  frm_kind;
  mmgf_group_t frm_group;
  logic [7:0]  frm_resp;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        fwd_valid;
  logic        fwd_pass;
  logic        report_tx;
  mmgf_group_t report_group;
  logic        query_tx;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          t0;
  // 10 MHz clock and cycle count
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  mmgf_top #(.TICK_CYCLES(TICK)) dut_u (
    .ref_clk_in(ref_clk), .rst_in(rst), .ce_in(ce), .frm_valid_in(frm_valid),
    .frm_from_rf_in(frm_from_rf), .frm_kind_in(frm_kind), .frm_group_in(frm_group),
    .frm_resp_sec_in(frm_resp), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .fwd_valid_out(fwd_valid), .fwd_pass_out(fwd_pass), .report_tx_out(report_tx),
    .report_group_out(report_group), .query_tx_out(query_tx));
  mmgf_far_model far_u (
    .ref_clk_in(ref_clk), .frm_valid_out(frm_valid), .frm_from_rf_out(frm_from_rf),
    .frm_kind_out(frm_kind), .frm_group_out(frm_group), .frm_resp_sec_out(frm_resp),
    .fwd_valid_in(fwd_valid), .fwd_pass_in(fwd_pass), .report_tx_in(report_tx),
    .report_group_in(report_group), .query_tx_in(query_tx));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // register write, one cycle strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // register read, data taken in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdc
  // send a frame and compare {valid, pass}
  task automatic frm(input logic rf, input mmgf_kind_t k, input mmgf_group_t g,
                     input logic [7:0] s, input logic [1:0] e);
    logic [1:0] r;
    far_u.send(rf, k, g, s, r);
    chk({30'h0, r}, {30'h0, e});
  endtask : frm
  task automatic secs(input int n);
    repeat (n * TICK) @(posedge ref_clk);
  endtask : secs
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h000a007d);
    // read data stand one cycle only, then return to zero
    @(posedge ref_clk);
    #1;
    chk(reg_rdata, 32'h0);
    rdc(8'h0c, 32'h000a007d);
    rdc(8'h10, 32'h0);
    rdc(8'h14, 32'h0);
    // a write is refused while the clock enable is low
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(8'h04, 32'hff);
    ce <= 1'b1;
    rdc(8'h04, 32'h0);
    // basic forwarding decisions
    frm(1'b0, MMGF_KIND_QGEN, 3'h0, 8'h00, 2'b10);
    frm(1'b0, MMGF_KIND_DATA, 3'h1, 8'h00, 2'b11);
    frm(1'b1, MMGF_KIND_DATA, 3'h0, 8'h00, 2'b11);
    frm(1'b1, MMGF_KIND_DATA, 3'h3, 8'h00, 2'b10);
    frm(1'b1, MMGF_KIND_REPORT, 3'h2, 8'h00, 2'b10);
    frm(1'b1, MMGF_KIND_LEAVE, 3'h2, 8'h00, 2'b10);
    // join, forwarding and delayed upstream report
    frm(1'b0, MMGF_KIND_REPORT, 3'h5, 8'h00, 2'b10);
    frm(1'b1, MMGF_KIND_DATA, 3'h5, 8'h00, 2'b11);
    rdc(8'h10, 32'h20);
    secs(11);
    chk({31'h0, far_u.rpt_seen[5]}, 32'h1);
    // administrative prohibits
    wr(8'h04, 32'h21);
    frm(1'b1, MMGF_KIND_DATA, 3'h5, 8'h00, 2'b10);
    frm(1'b1, MMGF_KIND_DATA, 3'h0, 8'h00, 2'b10);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h4);
    frm(1'b0, MMGF_KIND_DATA, 3'h1, 8'h00, 2'b10);
    wr(8'h00, 32'h0);
    // rf report cancels pending join and suppression sticks
    frm(1'b0, MMGF_KIND_REPORT, 3'h3, 8'h00, 2'b10);
    frm(1'b1, MMGF_KIND_REPORT, 3'h3, 8'h00, 2'b10);
    rdc(8'h10, 32'h828);
    secs(12);
    chk({31'h0, far_u.rpt_seen[3]}, 32'h0);
    frm(1'b0, MMGF_KIND_REPORT, 3'h3, 8'h00, 2'b10);
    secs(12);
    chk({31'h0, far_u.rpt_seen[3]}, 32'h0);
    // first query relayed, clears suppression, timers from query
    frm(1'b1, MMGF_KIND_QGRP, 3'h3, 8'h00, 2'b11);
    t0 = cyc;
    rdc(8'h0c, 32'h000a007d);
    rdc(8'h10, 32'h28);
    // rf report for an active group inside the response window suppresses
    frm(1'b1, MMGF_KIND_REPORT, 3'h3, 8'h00, 2'b10);
    rdc(8'h10, 32'h828);
    frm(1'b0, MMGF_KIND_LEAVE, 3'h5, 8'h00, 2'b11);
    rdc(8'h10, 32'h808);
    // second query 130 s later sets the interval from the gap
    while (cyc != t0 + 130 * TICK - 2) begin
      @(posedge ref_clk);
      #1;
    end
    frm(1'b1, MMGF_KIND_QGEN, 3'h0, 8'h07, 2'b11);
    rdc(8'h0c, 32'h00070082);
    // membership ages out after 2*130+7 s
    frm(1'b0, MMGF_KIND_LEAVE, 3'h3, 8'h00, 2'b11);
    frm(1'b0, MMGF_KIND_REPORT, 3'h3, 8'h00, 2'b10);
    secs(265);
    rdc(8'h10, 32'h08);
    secs(4);
    rdc(8'h10, 32'h0);
    // timer override and host role
    wr(8'h08, 32'h00030004);
    wr(8'h00, 32'h2);
    rdc(8'h08, 32'h00030004);
    rdc(8'h0c, 32'h00030004);
    wr(8'h00, 32'h3);
    frm(1'b1, MMGF_KIND_QGEN, 3'h0, 8'h00, 2'b10);
    secs(2);
    #1;
    far_u.clear();
    secs(12);
    #1;
    chk(far_u.qry_cnt, 32'h3);
    end_of_test();
  end
endmodule : mmgf_top_bench
